// ==== core/lisa_regs.svh ====
// low i/o space register offsets, field positions and reset values
// assumes inclusion by bare name from the package and the modules
`ifndef LISA_REGS_SVH
`define LISA_REGS_SVH
// ----------------------------------------
// address map
// ----------------------------------------
`define LISA_DATA_OFFSET      8'h20
`define LISA_IO_LAST          8'h3F
`define LISA_BIT_LAST         8'h1F
`define LISA_EXT_FIRST        8'h60
`define LISA_OFF_PB_IN        6'h03
`define LISA_OFF_PB_DIR       6'h04
`define LISA_OFF_PB_OUT       6'h05
`define LISA_OFF_PC_IN        6'h06
`define LISA_OFF_PC_DIR       6'h07
`define LISA_OFF_PC_OUT       6'h08
`define LISA_OFF_PD_IN        6'h09
`define LISA_OFF_PD_DIR       6'h0A
`define LISA_OFF_PD_OUT       6'h0B
`define LISA_OFF_TMR0_FLG     6'h15
`define LISA_OFF_TMR1_FLG     6'h16
`define LISA_OFF_TMR2_FLG     6'h17
`define LISA_OFF_PCHG_FLG     6'h1B
// ----------------------------------------
// implemented bits and reset values
// ----------------------------------------
`define LISA_PC_MASK          8'h7F
`define LISA_TMR0_MASK        8'h07
`define LISA_TMR1_MASK        8'h27
`define LISA_TMR2_MASK        8'h07
`define LISA_PCHG_MASK        8'h07
`define LISA_RST_VALUE        8'h00
`endif

// ==== core/lisa_pkg.sv ====
// types shared by the low i/o space block
// assumes lisa_regs.svh is on the include path
`include "lisa_regs.svh"
package lisa_pkg;
    // kind of access the core issues in one cycle
    typedef enum logic [2:0] {
        LISA_OP_NONE   = 3'b000,
        LISA_OP_IN     = 3'b001,
        LISA_OP_OUT    = 3'b010,
        LISA_OP_LOAD   = 3'b011,
        LISA_OP_STORE  = 3'b100,
        LISA_OP_SETBIT = 3'b101,
        LISA_OP_CLRBIT = 3'b110,
        LISA_OP_TEST   = 3'b111
    } lisa_op_type;
endpackage

// ==== core/lisa_port.sv ====
// one general purpose port: output data, direction, synchronised pins
// assumes pins are asynchronous; writes come already decoded from the core
`include "lisa_regs.svh"
module lisa_port
    import lisa_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       dir_we,
    input  wire logic       out_we,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    output logic      [7:0] dir_q,
    output logic      [7:0] out_q,
    output logic      [7:0] lvl_q
);
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] dat;
        logic [7:0] sync1;
        logic [7:0] sync2;
    } lisa_port_state_type;

    lisa_port_state_type state_reg;
    lisa_port_state_type state_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // unimplemented bits never store; pins pass both flops unmasked so no
    // gate sits inside the synchroniser
    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        if (dir_we) begin
            state_next.dir = wdata & IMPL_MASK;
        end
        if (out_we) begin
            state_next.dat = wdata & IMPL_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // pins drive their data bit only where direction is one
    assign pin_out = state_reg.dat;
    assign pin_oe  = state_reg.dir;
    assign dir_q   = state_reg.dir;
    assign out_q   = state_reg.dat;
    assign lvl_q   = state_reg.sync2 & IMPL_MASK;
endmodule

// ==== core/lisa_io_space.sv ====
// low i/o space: three ports, three timer flag sets, pin-change flags
// assumes one core access per cycle, reads answered combinationally
// Behaviour
// - set/clear single bit at io 0x00-0x1F
// - test single bit, report skip condition
// - writing one clears status flag
// - bit set/clear touches only addressed bit
// - in/out instructions address io 0x00-0x3F
// - data address equals io address plus 0x20
// - 0x60-0xFF reachable only by load/store
// - pin-change flags in bits 2..0
// - port c implements bits 6..0 only
`include "lisa_regs.svh"
module lisa_io_space
    import lisa_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  lisa_op_type      io_op,
    input  wire logic [7:0]  io_addr,
    input  wire logic [2:0]  io_bit,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_hit,
    output logic             io_skip_one,
    output logic             io_skip_zero,
    output logic             ext_sel,
    output logic      [7:0]  ext_addr,
    output logic             ext_we,
    output logic      [7:0]  ext_wdata,
    input  wire logic [7:0]  ext_rdata,
    input  wire logic [7:0]  tmr0_evt,
    input  wire logic [7:0]  tmr1_evt,
    input  wire logic [7:0]  tmr2_evt,
    input  wire logic [2:0]  pchg_evt,
    output logic      [7:0]  tmr0_flags,
    output logic      [7:0]  tmr1_flags,
    output logic      [7:0]  tmr2_flags,
    output logic      [2:0]  pchg_flags,
    input  wire logic [7:0]  pb_pin_in,
    output logic      [7:0]  pb_pin_out,
    output logic      [7:0]  pb_pin_oe,
    input  wire logic [7:0]  pc_pin_in,
    output logic      [7:0]  pc_pin_out,
    output logic      [7:0]  pc_pin_oe,
    input  wire logic [7:0]  pd_pin_in,
    output logic      [7:0]  pd_pin_out,
    output logic      [7:0]  pd_pin_oe
);
    typedef struct packed {
        logic [7:0] tmr0;
        logic [7:0] tmr1;
        logic [7:0] tmr2;
        logic [7:0] pchg;
    } lisa_flag_state_type;

    lisa_flag_state_type state_reg;
    lisa_flag_state_type state_next;

    logic       io_valid;
    logic [5:0] io_idx;
    logic       is_write;
    logic       is_read;
    logic       is_bitop;
    logic [7:0] bit_sel;
    logic [7:0] cur_val;
    logic [7:0] wr_val;
    logic [7:0] w1c_val;
    logic [7:0] pb_dir;
    logic [7:0] pb_dat;
    logic [7:0] pb_lvl;
    logic [7:0] pc_dir;
    logic [7:0] pc_dat;
    logic [7:0] pc_lvl;
    logic [7:0] pd_dir;
    logic [7:0] pd_dat;
    logic [7:0] pd_lvl;

    // ----------------------------------------
    // address translation
    // ----------------------------------------
    // io ops use the io number; load/store subtract the data offset
    always_comb begin
        io_valid = 1'b0;
        io_idx   = 6'h00;
        ext_sel  = 1'b0;
        unique case (io_op)
            LISA_OP_IN, LISA_OP_OUT: begin
                io_valid = (io_addr <= `LISA_IO_LAST);
                io_idx   = io_addr[5:0];
            end
            LISA_OP_SETBIT, LISA_OP_CLRBIT, LISA_OP_TEST: begin
                io_valid = (io_addr <= `LISA_BIT_LAST);
                io_idx   = io_addr[5:0];
            end
            LISA_OP_LOAD, LISA_OP_STORE: begin
                io_valid = (io_addr >= `LISA_DATA_OFFSET) && (io_addr < `LISA_EXT_FIRST);
                io_idx   = 6'(io_addr - `LISA_DATA_OFFSET);
                ext_sel  = (io_addr >= `LISA_EXT_FIRST);
            end
            LISA_OP_NONE: begin
                io_valid = 1'b0;
            end
        endcase
    end

    // extended space is passed on for load/store only, never for in/out
    assign ext_addr  = io_addr;
    assign ext_we    = ext_sel && (io_op == LISA_OP_STORE);
    assign ext_wdata = io_wdata;

    assign is_bitop = (io_op == LISA_OP_SETBIT) || (io_op == LISA_OP_CLRBIT);
    assign is_write = io_valid && ((io_op == LISA_OP_OUT) || (io_op == LISA_OP_STORE) || is_bitop);
    assign is_read  = io_valid && !is_write;
    assign bit_sel  = 8'h01 << io_bit;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // reserved locations and unimplemented bits read zero
    always_comb begin
        unique case (io_idx)
            `LISA_OFF_PB_IN:    cur_val = pb_lvl;
            `LISA_OFF_PB_DIR:   cur_val = pb_dir;
            `LISA_OFF_PB_OUT:   cur_val = pb_dat;
            `LISA_OFF_PC_IN:    cur_val = pc_lvl;
            `LISA_OFF_PC_DIR:   cur_val = pc_dir;
            `LISA_OFF_PC_OUT:   cur_val = pc_dat;
            `LISA_OFF_PD_IN:    cur_val = pd_lvl;
            `LISA_OFF_PD_DIR:   cur_val = pd_dir;
            `LISA_OFF_PD_OUT:   cur_val = pd_dat;
            `LISA_OFF_TMR0_FLG: cur_val = state_reg.tmr0;
            `LISA_OFF_TMR1_FLG: cur_val = state_reg.tmr1;
            `LISA_OFF_TMR2_FLG: cur_val = state_reg.tmr2;
            `LISA_OFF_PCHG_FLG: cur_val = state_reg.pchg;
            default:            cur_val = `LISA_RST_VALUE;
        endcase
    end

    assign io_hit       = io_valid;
    assign io_rdata     = ext_sel ? ext_rdata : (is_read ? cur_val : 8'h00);
    assign io_skip_one  = io_valid && (io_op == LISA_OP_TEST) && ((cur_val & bit_sel) != 8'h00);
    assign io_skip_zero = io_valid && (io_op == LISA_OP_TEST) && ((cur_val & bit_sel) == 8'h00);

    // ----------------------------------------
    // write value
    // ----------------------------------------
    // a bit op on a plain register is read-modify-write of the one bit;
    // on a flag register only the addressed bit may carry a one, so a set
    // clears that flag alone and a clear writes nothing
    always_comb begin
        wr_val  = io_wdata;
        w1c_val = io_wdata;
        if (io_op == LISA_OP_SETBIT) begin
            wr_val  = cur_val | bit_sel;
            w1c_val = bit_sel;
        end else if (io_op == LISA_OP_CLRBIT) begin
            wr_val  = cur_val & ~bit_sel;
            w1c_val = 8'h00;
        end
    end

    // ----------------------------------------
    // sticky flags
    // ----------------------------------------
    // a new event in the clearing cycle wins, so no event is lost
    function automatic logic [7:0] lisa_flag_upd(input logic [7:0] cur, input logic [7:0] evt,
                                                 input logic clr, input logic [7:0] w1c,
                                                 input logic [7:0] msk);
        logic [7:0] kept;
        kept = clr ? (cur & ~w1c) : cur;
        return (kept | evt) & msk;
    endfunction

    always_comb begin
        state_next      = state_reg;
        state_next.tmr0 = lisa_flag_upd(state_reg.tmr0, tmr0_evt,
                                        is_write && (io_idx == `LISA_OFF_TMR0_FLG), w1c_val, `LISA_TMR0_MASK);
        state_next.tmr1 = lisa_flag_upd(state_reg.tmr1, tmr1_evt,
                                        is_write && (io_idx == `LISA_OFF_TMR1_FLG), w1c_val, `LISA_TMR1_MASK);
        state_next.tmr2 = lisa_flag_upd(state_reg.tmr2, tmr2_evt,
                                        is_write && (io_idx == `LISA_OFF_TMR2_FLG), w1c_val, `LISA_TMR2_MASK);
        state_next.pchg = lisa_flag_upd(state_reg.pchg, {5'h00, pchg_evt},
                                        is_write && (io_idx == `LISA_OFF_PCHG_FLG), w1c_val, `LISA_PCHG_MASK);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tmr0_flags = state_reg.tmr0;
    assign tmr1_flags = state_reg.tmr1;
    assign tmr2_flags = state_reg.tmr2;
    assign pchg_flags = state_reg.pchg[2:0];

    // ----------------------------------------
    // ports
    // ----------------------------------------
    lisa_port #(.IMPL_MASK(8'hFF)) u_port_b (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .dir_we  (is_write && (io_idx == `LISA_OFF_PB_DIR)),
        .out_we  (is_write && (io_idx == `LISA_OFF_PB_OUT)),
        .wdata   (wr_val),
        .pin_in  (pb_pin_in),
        .pin_out (pb_pin_out),
        .pin_oe  (pb_pin_oe),
        .dir_q   (pb_dir),
        .out_q   (pb_dat),
        .lvl_q   (pb_lvl)
    );

    lisa_port #(.IMPL_MASK(`LISA_PC_MASK)) u_port_c (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .dir_we  (is_write && (io_idx == `LISA_OFF_PC_DIR)),
        .out_we  (is_write && (io_idx == `LISA_OFF_PC_OUT)),
        .wdata   (wr_val),
        .pin_in  (pc_pin_in),
        .pin_out (pc_pin_out),
        .pin_oe  (pc_pin_oe),
        .dir_q   (pc_dir),
        .out_q   (pc_dat),
        .lvl_q   (pc_lvl)
    );

    lisa_port #(.IMPL_MASK(8'hFF)) u_port_d (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .dir_we  (is_write && (io_idx == `LISA_OFF_PD_DIR)),
        .out_we  (is_write && (io_idx == `LISA_OFF_PD_OUT)),
        .wdata   (wr_val),
        .pin_in  (pd_pin_in),
        .pin_out (pd_pin_out),
        .pin_oe  (pd_pin_oe),
        .dir_q   (pd_dir),
        .out_q   (pd_dat),
        .lvl_q   (pd_lvl)
    );
endmodule

// ==== bench/lisa_io_space_props.sv ====
// concurrent checks on the low i/o space block, watching its ports only
// assumes one access per cycle and flags that stay set when an event meets a clear
module lisa_io_space_props
    import lisa_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input lisa_op_type      io_op,
    input wire logic [7:0]  io_addr,
    input wire logic [2:0]  io_bit,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_hit,
    input wire logic        io_skip_one,
    input wire logic        io_skip_zero,
    input wire logic        ext_sel,
    input wire logic [7:0]  tmr0_evt,
    input wire logic [7:0]  tmr0_flags,
    input wire logic [2:0]  pchg_evt,
    input wire logic [2:0]  pchg_flags,
    input wire logic [7:0]  pb_pin_oe,
    input wire logic [7:0]  pc_pin_oe,
    input wire logic [7:0]  pc_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // decoded access kinds
    // ----------------------------------------
    logic bit_op;
    logic ld_st;
    assign bit_op = io_op inside {LISA_OP_SETBIT, LISA_OP_CLRBIT, LISA_OP_TEST};
    assign ld_st  = io_op inside {LISA_OP_LOAD, LISA_OP_STORE};
    // a quiet cycle on the timer events keeps the flag arithmetic exact
    sequence s_clr0;
        io_op == LISA_OP_OUT && io_addr == 8'h15 && tmr0_evt == 8'h00;
    endsequence
    sequence s_set0;
        io_op == LISA_OP_SETBIT && io_addr == 8'h15 && tmr0_evt == 8'h00;
    endsequence
    property p_bit_range;
        bit_op && io_addr > 8'h1F |-> !io_hit;
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit op above 0x1F accepted");
    property p_skip;
        io_op == LISA_OP_TEST && io_hit |-> io_skip_one == io_rdata[io_bit] && io_skip_zero == !io_rdata[io_bit];
    endproperty
    a_skip: assert property (p_skip) else $error("skip outputs disagree with tested bit");
    property p_w1c;
        s_clr0 |=> tmr0_flags == ($past(tmr0_flags) & ~$past(io_wdata));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one clear wrong");
    property p_setbit;
        s_set0 |=> tmr0_flags == ($past(tmr0_flags) & ~(8'h01 << $past(io_bit)));
    endproperty
    a_setbit: assert property (p_setbit) else $error("single bit op touched other flags");
    property p_io_range;
        io_op inside {LISA_OP_IN, LISA_OP_OUT} |-> io_hit == (io_addr <= 8'h3F);
    endproperty
    a_io_range: assert property (p_io_range) else $error("in/out range wrong");
    property p_ld_low;
        ld_st && io_addr < 8'h20 |-> !io_hit && !ext_sel;
    endproperty
    a_ld_low: assert property (p_ld_low) else $error("load/store below offset accepted");
    property p_ext;
        ext_sel == (ld_st && io_addr >= 8'h60);
    endproperty
    a_ext: assert property (p_ext) else $error("extended select wrong");
    property p_pchg;
        pchg_evt[0] |=> pchg_flags[0];
    endproperty
    a_pchg: assert property (p_pchg) else $error("pin change flag not set");
    property p_pc7;
        pc_pin_oe[7] == 1'b0 && pc_pin_out[7] == 1'b0;
    endproperty
    a_pc7: assert property (p_pc7) else $error("port c bit 7 driven");
    property p_oe;
        io_op == LISA_OP_OUT && io_addr == 8'h04 |=> pb_pin_oe == $past(io_wdata);
    endproperty
    a_oe: assert property (p_oe) else $error("direction write not on enables");
endmodule

// ==== bench/lisa_ext_model.sv ====
// far-side model of the extended data space reached by load and store
// assumes ext_* follow the core access of the same cycle
module lisa_ext_model (
    input  wire logic       sys_clk,
    input  wire logic       ext_sel,
    input  wire logic [7:0] ext_addr,
    input  wire logic       ext_we,
    input  wire logic [7:0] ext_wdata,
    output logic      [7:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem_reg [256];
    logic [7:0] last_reg = 8'h00;
    // unselected bus shows the inverse of the last value so a stale read cannot pass
    assign ext_rdata = ext_sel ? mem_reg[ext_addr] : ~last_reg;
    // store lands on the edge that takes it
    always @(posedge sys_clk) begin
        if (ext_sel) last_reg <= ext_rdata;
        if (ext_we) mem_reg[ext_addr] <= ext_wdata;
    end
endmodule

// ==== bench/lisa_io_space_bench.sv ====
// self-checking bench for the low i/o space block
// assumes the core side is driven 1 ns after each rising edge
module lisa_io_space_bench
    import lisa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, arst_n = 1'b0, io_hit, io_skip_one, io_skip_zero, ext_sel, ext_we, hit, sk1, sk0;
    lisa_op_type io_op = LISA_OP_NONE;
    logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, io_rdata, ext_addr, ext_wdata, ext_rdata, rd, base, mask;
    logic [2:0]  io_bit = 3'h0, pchg_evt = 3'h0, pchg_flags;
    logic [7:0]  tmr0_evt = 8'h00, tmr1_evt = 8'h00, tmr2_evt = 8'h00, tmr0_flags, tmr1_flags, tmr2_flags;
    logic [7:0]  pb_pin_in = 8'h96, pc_pin_in = 8'hFF, pd_pin_in = 8'h5A;
    logic [7:0]  pb_pin_out, pb_pin_oe, pc_pin_out, pc_pin_oe, pd_pin_out, pd_pin_oe;
    logic [23:0] oes, outs, pins;
    int          n_mismatch = 0, num_checks = 0;
    assign oes  = {pd_pin_oe, pc_pin_oe, pb_pin_oe};
    assign outs = {pd_pin_out, pc_pin_out, pb_pin_out};
    assign pins = {pd_pin_in, pc_pin_in, pb_pin_in};
    lisa_io_space dut (.sys_clk, .arst_n, .io_op, .io_addr, .io_bit, .io_wdata, .io_rdata, .io_hit, .io_skip_one,
        .io_skip_zero, .ext_sel, .ext_addr, .ext_we, .ext_wdata, .ext_rdata, .tmr0_evt, .tmr1_evt, .tmr2_evt,
        .pchg_evt, .tmr0_flags, .tmr1_flags, .tmr2_flags, .pchg_flags, .pb_pin_in, .pb_pin_out, .pb_pin_oe,
        .pc_pin_in, .pc_pin_out, .pc_pin_oe, .pd_pin_in, .pd_pin_out, .pd_pin_oe);
    lisa_ext_model u_ext (.sys_clk, .ext_sel, .ext_addr, .ext_we, .ext_wdata, .ext_rdata);
    always #25 sys_clk = ~sys_clk;
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    // request stands until the taking edge; answers are sampled mid-cycle where settled
    task automatic acc(input lisa_op_type op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
        io_op = op;
        io_addr = a;
        io_bit = b;
        io_wdata = d;
        @(negedge sys_clk);
        rd = io_rdata;
        hit = io_hit;
        sk1 = io_skip_one;
        sk0 = io_skip_zero;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle burst on every event input, with the core idle
    task automatic pulse();
        io_op = LISA_OP_NONE;
        {tmr0_evt, tmr1_evt, tmr2_evt, pchg_evt} = {8'hFF, 8'hFF, 8'hFF, 3'h7};
        @(posedge sys_clk);
        #1;
        {tmr0_evt, tmr1_evt, tmr2_evt, pchg_evt} = 27'h0;
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    // software here never writes reserved bits; it writes reserved addresses only in the rejected setbit at 0x20 and out to 0x60
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            base = 8'h03 + 8'(3 * i);
            mask = (i == 1) ? 8'h7F : 8'hFF;
            chk("reset oe", 8'h00, oes[8*i +: 8]);
            acc(LISA_OP_OUT, base + 8'h01, 3'h0, mask);
            acc(LISA_OP_STORE, base + 8'h22, 3'h0, mask);
            acc(LISA_OP_IN, base + 8'h01, 3'h0, 8'h00);
            chk("dir", mask, rd);
            acc(LISA_OP_LOAD, base + 8'h22, 3'h0, 8'h00);
            chk("out", mask, rd);
            acc(LISA_OP_IN, base, 3'h0, 8'h00);
            chk("pins", pins[8*i +: 8] & mask, rd);
            chk("oe", mask, oes[8*i +: 8]);
            chk("drive", mask, outs[8*i +: 8]);
        end
        acc(LISA_OP_CLRBIT, 8'h0A, 3'h3, 8'h00);
        acc(LISA_OP_SETBIT, 8'h20, 3'h0, 8'h00);
        chk("bit op hit", 8'h00, {7'h00, hit});
        chk("clrbit dir", 8'hF7, pd_pin_oe);
        acc(LISA_OP_SETBIT, 8'h0A, 3'h3, 8'h00);
        chk("setbit dir", 8'hFF, pd_pin_oe);
        acc(LISA_OP_IN, 8'h40, 3'h0, 8'h00);
        chk("in hit", 8'h00, {7'h00, hit});
        acc(LISA_OP_IN, 8'h3F, 3'h0, 8'h00);
        chk("in top hit", 8'h01, {7'h00, hit});
        acc(LISA_OP_LOAD, 8'h04, 3'h0, 8'h00);
        chk("load low hit", 8'h00, {7'h00, hit});
        acc(LISA_OP_STORE, 8'h60, 3'h0, 8'h77);
        acc(LISA_OP_STORE, 8'hFF, 3'h0, 8'h3C);
        acc(LISA_OP_OUT, 8'h60, 3'h0, 8'h11);
        chk("out ext hit", 8'h00, {7'h00, hit});
        acc(LISA_OP_LOAD, 8'h60, 3'h0, 8'h00);
        chk("ext low", 8'h77, rd);
        acc(LISA_OP_LOAD, 8'hFF, 3'h0, 8'h00);
        chk("ext top", 8'h3C, rd);
        pulse();
        acc(LISA_OP_IN, 8'h15, 3'h0, 8'h00);
        chk("tmr0", 8'h07, rd);
        acc(LISA_OP_IN, 8'h16, 3'h0, 8'h00);
        chk("tmr1", 8'h27, rd);
        acc(LISA_OP_LOAD, 8'h37, 3'h0, 8'h00);
        chk("tmr2", 8'h07, rd);
        acc(LISA_OP_IN, 8'h1B, 3'h0, 8'h00);
        chk("pchg", 8'h07, rd);
        acc(LISA_OP_SETBIT, 8'h15, 3'h1, 8'h00);
        acc(LISA_OP_CLRBIT, 8'h15, 3'h0, 8'h00);
        acc(LISA_OP_TEST, 8'h15, 3'h1, 8'h00);
        chk("skip zero", 8'h01, {7'h00, sk0});
        acc(LISA_OP_TEST, 8'h15, 3'h0, 8'h00);
        chk("skip one", 8'h01, {7'h00, sk1});
        chk("tmr0 bitop", 8'h05, tmr0_flags);
        acc(LISA_OP_OUT, 8'h15, 3'h0, 8'h04);
        chk("tmr0 w1c", 8'h01, tmr0_flags);
        // an event in the clearing cycle must keep its flag set
        tmr0_evt = 8'h01;
        acc(LISA_OP_OUT, 8'h15, 3'h0, 8'h01);
        tmr0_evt = 8'h00;
        chk("tmr0 set wins", 8'h01, tmr0_flags);
        acc(LISA_OP_OUT, 8'h16, 3'h0, 8'h20);
        acc(LISA_OP_OUT, 8'h16, 3'h0, 8'h00);
        chk("tmr1 w1c", 8'h07, tmr1_flags);
        acc(LISA_OP_STORE, 8'h37, 3'h0, 8'h01);
        acc(LISA_OP_SETBIT, 8'h1B, 3'h2, 8'h00);
        acc(LISA_OP_NONE, 8'h00, 3'h0, 8'h00);
        chk("tmr2 store", 8'h06, tmr2_flags);
        chk("pchg bitop", 8'h03, {5'h00, pchg_flags});
        final_report();
    end
    // watchdog: the sequence needs about 45 cycles
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
endmodule
bind lisa_io_space lisa_io_space_props u_props (.sys_clk, .arst_n, .io_op, .io_addr, .io_bit, .io_wdata, .io_rdata,
    .io_hit, .io_skip_one, .io_skip_zero, .ext_sel, .tmr0_evt, .tmr0_flags, .pchg_evt, .pchg_flags, .pb_pin_oe,
    .pc_pin_oe, .pc_pin_out);
